// ### rtl/sdcf_fetch_timing.v
// sdram code fetch timing: paces instruction execution and sdram commands
// assumes the sequencer and sdram controller share ref_clk with this block
// Summary of operation
// - The first instruction executes only after activate, the activate-to-column delay, the CAS latency and three times the packing ratio more cycles.
// - The pipeline has fetch, decode and execute stages, each taking two cycles per instruction during fill under two-word packing.
// - With the pipeline full, sequential code executes one instruction every packing-ratio cycles under full-width or two-word packing, two for the latter.
// - Fill delay is activate-to-column delay plus CAS latency plus three times the packing ratio of 1, 2, 3 or 6.
// - With full-width fetch and no packing the first instruction executes in the sixth cycle.
// - Under full-width or two-word packing, sequential code crossing a page or bank keeps the pipeline and stalls for precharge and activate.
// - A delayed branch in the same page runs its two slot instructions without a flush, four cycles cheaper.
// - A non-delayed branch in the same page flushes and refills, costing six cycles past the read-to-read delay.
// - A branch off page precharges, activates and refills, flushing only when not delayed, with two refill cycles instead of six when delayed.
// - Under two-word packing a loop with data-memory access fetches with two reads then four dummy reads, six cycles per iteration.
// - A loop with program-memory access and cache on takes eight cycles when fetched and one per iteration on a hit.
// - With the cache off such a loop always fetches from sdram at eight cycles per iteration.
// - The first three cached iterations only load the cache and the fourth onward run from it.
// - Under two-word packing each logical address is fetched as two consecutive physical words.
// - A packing select input chooses full-width, 32-bit, 16-bit or 8-bit external packing.
`timescale 1ns/10ps
`include "sdcf_fetch_map.vh"

module sdcf_fetch_timing #(
	parameter PHYS_W = 32,
	parameter [7:0] T_RCD = `SDCF_T_RCD,
	parameter [7:0] CAS_LAT = `SDCF_CAS_LAT,
	parameter [7:0] T_RP = `SDCF_T_RP,
	parameter [7:0] T_DRD = `SDCF_T_DRD
) (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// configuration
	input wire [1:0] instrPackingSelect,
	input wire cacheEnable,
	// sequencer request
	input wire reqValid,
	input wire [23:0] reqAddr,
	input wire delayedBranch,
	input wire [1:0] loopMode,
	input wire loopFirst,
	output wire reqReady,
	// execution status
	output reg execStrobe,
	output reg stallActive,
	output reg flushPulse,
	output reg [2:0] pipeStage,
	output reg seqFetch,
	output reg cacheHit,
	// sdram controller commands
	output reg memActivate,
	output reg memPrecharge,
	output reg memRead,
	output reg memDummyRead,
	output reg [PHYS_W-1:0] memAddr
);

	// ------------------------------------------------------------
	// packing ratio
	// ------------------------------------------------------------
	// physical fetches per 48-bit instruction
	function [3:0] packRatio;
		input [1:0] sel;
		begin
			case (sel)
				`SDCF_PACK_48: packRatio = 4'h1;
				`SDCF_PACK_32: packRatio = 4'h2;
				`SDCF_PACK_16: packRatio = 4'h3;
				default: packRatio = 4'h6;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	// command engine states
	localparam ST_RUN = 2'h0, ST_PRE = 2'h1, ST_ACT = 2'h2;
	reg busy_q, rowOpen_q, fill_q;
	reg [1:0] state_q;
	reg [7:0] totalCnt_q, phaseCnt_q;
	reg [3:0] readLeft_q, stageDiv_q;
	reg [2:0] dummyLeft_q, loopIter_q;
	reg [PHYS_W-1:0] lastPhys_q;
	wire [PHYS_W-1:0] physAddr;
	wire isSeq, samePage, accept;
	wire [3:0] ratio;
	wire [7:0] ratio8, fillWin;
	reg [7:0] dly;
	reg doPre, doAct, doFlush, doStall, hit;
	reg [3:0] reads;
	reg [2:0] dummies;

	sdcf_addr_xlate #(
		.PHYS_W(PHYS_W)
	) sdcf_addr_xlate_i (
		.logicalAddr(reqAddr),
		.packSel(instrPackingSelect),
		.lastPhys(lastPhys_q),
		.physAddr(physAddr),
		.isSeq(isSeq),
		.samePage(samePage)
	);

	// one instruction in flight; the next is taken only once this one executes
	assign reqReady = ~busy_q;
	assign accept = reqValid & ~busy_q;
	assign ratio = packRatio(instrPackingSelect);
	assign ratio8 = {4'h0, ratio};
	// refill occupies the last three stage slots before execution
	assign fillWin = `SDCF_FILL_STAGES * ratio8;

	// ------------------------------------------------------------
	// cost of the offered fetch
	// ------------------------------------------------------------
	// loops are classed first: the burst is broken whatever the address
	always @* begin
		dly = ratio8;
		doPre = 1'b0;
		doAct = 1'b0;
		doFlush = 1'b0;
		doStall = 1'b0;
		hit = 1'b0;
		reads = ratio;
		dummies = 3'h0;
		if (loopMode == `SDCF_LOOP_DM) begin
			dly = `SDCF_DM_LOOP_CYC;
			dummies = `SDCF_DUMMY_READS;
		end else if (loopMode == `SDCF_LOOP_PM) begin
			if (cacheEnable && !loopFirst && loopIter_q >= `SDCF_CACHE_LOAD_ITERS) begin
				dly = `SDCF_CACHE_HIT_CYC;
				reads = 4'h0;
				hit = 1'b1;
			end else begin
				dly = `SDCF_PM_LOOP_CYC;
			end
		end else if (!rowOpen_q) begin
			// cold start: open the row, wait CAS, fill three stages
			doAct = 1'b1;
			doFlush = 1'b1;
			doStall = 1'b1;
			dly = T_RCD + CAS_LAT + fillWin;
		end else if (!samePage) begin
			doPre = 1'b1;
			doAct = 1'b1;
			doStall = 1'b1;
			if (isSeq) begin
				dly = ratio8 + T_DRD + T_RP + T_RCD + `SDCF_SEQ_CROSS_EXTRA;
			end else if (delayedBranch) begin
				dly = ratio8 + T_DRD + T_RP + T_RCD + `SDCF_OFFPAGE_EXTRA + `SDCF_DB_REFILL;
			end else begin
				dly = ratio8 + T_DRD + T_RP + T_RCD + `SDCF_OFFPAGE_EXTRA + `SDCF_BR_REFILL;
				doFlush = 1'b1;
			end
		end else if (!isSeq) begin
			doStall = 1'b1;
			if (delayedBranch) begin
				dly = ratio8 + T_DRD + `SDCF_DB_REFILL;
			end else begin
				dly = ratio8 + T_DRD + `SDCF_BR_REFILL;
				doFlush = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// execution pacing
	// ------------------------------------------------------------
	// a single down-counter sets the execute moment; command timing below
	// finishes inside it, except in a data-memory loop under 16-bit or 8-bit packing, where the reads and four dummy reads outlast the six cycles
	always @(posedge ref_clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			totalCnt_q <= 8'h00;
			execStrobe <= 1'b0;
			stallActive <= 1'b0;
			flushPulse <= 1'b0;
			seqFetch <= 1'b0;
			cacheHit <= 1'b0;
			fill_q <= 1'b0;
		end else begin
			execStrobe <= 1'b0;
			flushPulse <= 1'b0;
			if (accept) begin
				busy_q <= 1'b1;
				totalCnt_q <= dly;
				stallActive <= doStall;
				flushPulse <= doFlush;
				fill_q <= doFlush;
				seqFetch <= isSeq & samePage & rowOpen_q;
				cacheHit <= hit;
			end else if (busy_q) begin
				totalCnt_q <= totalCnt_q - 8'h01;
				if (totalCnt_q == 8'h01) begin
					busy_q <= 1'b0;
					execStrobe <= 1'b1;
					stallActive <= 1'b0;
					fill_q <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// pipeline stage occupancy
	// ------------------------------------------------------------
	// bit 0 fetch, bit 1 decode, bit 2 execute; each stage takes ratio cycles
	always @(posedge ref_clk) begin
		if (rst) begin
			pipeStage <= 3'h0;
			stageDiv_q <= 4'h1;
		end else if (accept) begin
			stageDiv_q <= ratio;
			if (doFlush) begin
				pipeStage <= 3'h0;
			end
		end else if (busy_q && fill_q && totalCnt_q <= fillWin) begin
			if (stageDiv_q == 4'h1) begin
				pipeStage <= {pipeStage[1:0], 1'b1};
				stageDiv_q <= ratio;
			end else begin
				stageDiv_q <= stageDiv_q - 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// loop iteration tracking
	// ------------------------------------------------------------
	// saturates: only the fourth-iteration threshold matters
	always @(posedge ref_clk) begin
		if (rst) begin
			loopIter_q <= 3'h0;
		end else if (accept && loopMode == `SDCF_LOOP_PM) begin
			if (loopFirst) begin
				loopIter_q <= 3'h1;
			end else if (loopIter_q != 3'h7) begin
				loopIter_q <= loopIter_q + 3'h1;
			end
		end else if (accept && loopMode == `SDCF_LOOP_NONE) begin
			loopIter_q <= 3'h0;
		end
	end

	// ------------------------------------------------------------
	// row command engine
	// ------------------------------------------------------------
	// precharge then activate before reads; the row is marked open at once,
	// which is safe because the next request waits for execution
	always @(posedge ref_clk) begin
		if (rst) begin
			state_q <= ST_RUN;
			phaseCnt_q <= 8'h00;
			rowOpen_q <= 1'b0;
			memActivate <= 1'b0;
			memPrecharge <= 1'b0;
		end else begin
			memActivate <= 1'b0;
			memPrecharge <= 1'b0;
			case (state_q)
				ST_RUN: begin
					if (accept && doPre) begin
						state_q <= ST_PRE;
						phaseCnt_q <= T_RP;
						memPrecharge <= 1'b1;
					end else if (accept && doAct) begin
						state_q <= ST_ACT;
						phaseCnt_q <= T_RCD;
						memActivate <= 1'b1;
					end
					if (accept && doAct) begin
						rowOpen_q <= 1'b1;
					end
				end
				ST_PRE: begin
					if (phaseCnt_q <= 8'h01) begin
						state_q <= ST_ACT;
						phaseCnt_q <= T_RCD;
						memActivate <= 1'b1;
					end else begin
						phaseCnt_q <= phaseCnt_q - 8'h01;
					end
				end
				ST_ACT: begin
					if (phaseCnt_q <= 8'h01) begin
						state_q <= ST_RUN;
					end else begin
						phaseCnt_q <= phaseCnt_q - 8'h01;
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// read issue
	// ------------------------------------------------------------
	// reads wait for the row; dummy reads follow the real ones at the same
	// address to break the burst
	always @(posedge ref_clk) begin
		if (rst) begin
			readLeft_q <= 4'h0;
			dummyLeft_q <= 3'h0;
			memRead <= 1'b0;
			memDummyRead <= 1'b0;
			memAddr <= {PHYS_W{1'b0}};
			lastPhys_q <= {PHYS_W{1'b0}};
		end else begin
			memRead <= 1'b0;
			memDummyRead <= 1'b0;
			if (accept) begin
				readLeft_q <= reads;
				dummyLeft_q <= dummies;
				if (reads != 4'h0) begin
					memAddr <= physAddr;
					// last word of this instruction, for the next compare
					lastPhys_q <= physAddr + {{(PHYS_W-4){1'b0}}, reads} -
						{{(PHYS_W-1){1'b0}}, 1'b1};
				end
			end else if (state_q == ST_RUN && busy_q) begin
				if (readLeft_q != 4'h0) begin
					memRead <= 1'b1;
					readLeft_q <= readLeft_q - 4'h1;
					if (memRead) begin
						memAddr <= memAddr + {{(PHYS_W-1){1'b0}}, 1'b1};
					end
				end else if (dummyLeft_q != 3'h0) begin
					memDummyRead <= 1'b1;
					dummyLeft_q <= dummyLeft_q - 3'h1;
				end
			end
		end
	end

endmodule

// ### rtl/sdcf_fetch_map.vh
// constants for the sdram code fetch timing block
// assumes one clock: sdram clock equal to core clock
`ifndef SDCF_FETCH_MAP_VH
`define SDCF_FETCH_MAP_VH

// ------------------------------------------------------------
// packing select encodings (external width : 48-bit word)
// ------------------------------------------------------------
`define SDCF_PACK_48 2'h0
`define SDCF_PACK_32 2'h1
`define SDCF_PACK_16 2'h2
`define SDCF_PACK_8 2'h3

// ------------------------------------------------------------
// loop mode encodings
// ------------------------------------------------------------
`define SDCF_LOOP_NONE 2'h0
`define SDCF_LOOP_DM 2'h1
`define SDCF_LOOP_PM 2'h2

// ------------------------------------------------------------
// timing counts in sdram clock cycles
// ------------------------------------------------------------
`define SDCF_T_RCD 8'h01
`define SDCF_CAS_LAT 8'h02
`define SDCF_T_RP 8'h01
`define SDCF_T_DRD 8'h02
`define SDCF_FILL_STAGES 8'h03
`define SDCF_BR_REFILL 8'h06
`define SDCF_DB_REFILL 8'h02
`define SDCF_SEQ_CROSS_EXTRA 8'h02
`define SDCF_OFFPAGE_EXTRA 8'h01
`define SDCF_DM_LOOP_CYC 8'h06
`define SDCF_PM_LOOP_CYC 8'h08
`define SDCF_CACHE_HIT_CYC 8'h01
`define SDCF_DUMMY_READS 3'h4
`define SDCF_CACHE_LOAD_ITERS 3'h3

// ------------------------------------------------------------
// address layout
// ------------------------------------------------------------
`define SDCF_START_ADDR 24'h200000
`define SDCF_COL_BITS 8

`endif

// ### rtl/sdcf_addr_xlate.v
// logical to physical instruction address translation and fetch classification
// assumes lastPhys holds the last physical word of the previous fetch
`timescale 1ns/10ps
`include "sdcf_fetch_map.vh"

module sdcf_addr_xlate #(
	parameter PHYS_W = 32,
	parameter COL_BITS = `SDCF_COL_BITS,
	parameter [23:0] START_ADDR = `SDCF_START_ADDR
) (
	// translation inputs
	input wire [23:0] logicalAddr,
	input wire [1:0] packSel,
	input wire [PHYS_W-1:0] lastPhys,
	// results
	output wire [PHYS_W-1:0] physAddr,
	output wire isSeq,
	output wire samePage
);

	// ------------------------------------------------------------
	// stride per packing mode
	// ------------------------------------------------------------
	// physical words per logical address: 1, 2, 4 or 8
	function [1:0] packShift;
		input [1:0] sel;
		begin
			case (sel)
				`SDCF_PACK_48: packShift = 2'h0;
				`SDCF_PACK_32: packShift = 2'h1;
				`SDCF_PACK_16: packShift = 2'h2;
				default: packShift = 2'h3;
			endcase
		end
	endfunction

	wire [PHYS_W-1:0] offset;
	wire [PHYS_W-1:0] nextPhys;

	// start + (logical - start) * stride, same as logical*k - (k-1)*start
	assign offset = {{(PHYS_W-24){1'b0}}, logicalAddr - START_ADDR} << packShift(packSel);
	assign physAddr = {{(PHYS_W-24){1'b0}}, START_ADDR} + offset;

	// sequential when this fetch follows the last word of the previous one
	assign nextPhys = lastPhys + {{(PHYS_W-1){1'b0}}, 1'b1};
	assign isSeq = (physAddr == nextPhys);
	// row and bank bits sit above the column bits
	assign samePage = (physAddr[PHYS_W-1:COL_BITS] == lastPhys[PHYS_W-1:COL_BITS]);

endmodule

// ### verification/sdcf_fetch_timing_asserts.sv
// assertions for the sdram code fetch timing block
// assumes default timing: activate-to-column 1, cas 2, precharge 1
`timescale 1ns/10ps
module sdcf_fetch_timing_asserts #(
	parameter PHYS_W = 32
) (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// request side
	input wire [1:0] instrPackingSelect,
	input wire reqValid,
	input wire [1:0] loopMode,
	input wire reqReady,
	// status
	input wire execStrobe,
	input wire stallActive,
	input wire flushPulse,
	input wire seqFetch,
	input wire cacheHit,
	// sdram commands
	input wire memActivate,
	input wire memPrecharge,
	input wire memRead,
	input wire memDummyRead,
	input wire [PHYS_W-1:0] memAddr
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	reg rowSeen_q;
	wire acc = reqValid && reqReady;
	wire cold = acc && !rowSeen_q && loopMode == 2'h0;
	// a fetch is cold only until the first accept after reset
	always @(posedge ref_clk) begin
		if (rst)
			rowSeen_q <= 1'h0;
		else if (acc)
			rowSeen_q <= 1'h1;
	end
	chk_cold_fill: assert property (cold && instrPackingSelect == 2'h1
		|=> (flushPulse && memActivate && !execStrobe) ##1 (!execStrobe)[*8] ##1 execStrobe)
		else $error("cold fill latency wrong");
	chk_full_width: assert property (cold && instrPackingSelect == 2'h0
		|-> ##7 execStrobe) else $error("full width fill wrong");
	chk_seq_pace: assert property (acc && instrPackingSelect == 2'h1
		&& loopMode == 2'h0 ##1 seqFetch |=> !execStrobe ##1 execStrobe)
		else $error("sequential pace wrong");
	chk_dm_loop: assert property (acc && loopMode == 2'h1 |-> ##7 execStrobe)
		else $error("dm loop iteration wrong");
	chk_pm_hit: assert property (acc && loopMode == 2'h2 ##1 cacheHit
		|=> execStrobe && !memRead) else $error("cache hit not one cycle");
	chk_pm_fetch: assert property (acc && loopMode == 2'h2 ##1 !cacheHit
		|-> ##8 execStrobe) else $error("pm loop iteration wrong");
	chk_flush_stall: assert property (flushPulse |-> stallActive)
		else $error("flush without stall");
	chk_pre_act: assert property (memPrecharge |=> memActivate)
		else $error("activate late after precharge");
	chk_act_read: assert property (memActivate |-> ##2 memRead)
		else $error("read late after activate");
	chk_dummy_run: assert property ($rose(memDummyRead)
		|-> memDummyRead[*4] ##1 !memDummyRead) else $error("dummy run not four");
	chk_word_pair: assert property (instrPackingSelect == 2'h1 && memRead
		&& $past(memRead) && !$past(memRead, 2) |-> memAddr == $past(memAddr) + 32'h1)
		else $error("pair words not consecutive");
endmodule
bind sdcf_fetch_timing sdcf_fetch_timing_asserts #(.PHYS_W(PHYS_W)) sdcf_fetch_timing_asserts_i (
	.ref_clk(ref_clk), .rst(rst), .instrPackingSelect(instrPackingSelect),
	.reqValid(reqValid), .loopMode(loopMode), .reqReady(reqReady),
	.execStrobe(execStrobe), .stallActive(stallActive), .flushPulse(flushPulse),
	.seqFetch(seqFetch),
	.cacheHit(cacheHit), .memActivate(memActivate), .memPrecharge(memPrecharge),
	.memRead(memRead), .memDummyRead(memDummyRead), .memAddr(memAddr));

// ### verification/sdcf_sdram_model.sv
// behavioural sdram seen through the controller command pulses
// assumes one clock shared with the fetch block; nothing is driven back
`timescale 1ns/10ps
module sdcf_sdram_model (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// commands
	input wire memActivate,
	input wire memPrecharge,
	input wire memRead,
	input wire memDummyRead,
	input wire [31:0] memAddr,
	// observation
	output reg [15:0] rdCnt_q,
	output reg [15:0] dumCnt_q,
	output reg [15:0] actCnt_q,
	output reg [15:0] preCnt_q,
	output reg [15:0] errCnt_q,
	output reg [31:0] lastAddr_q
);
	reg rowOpen_q;
	// a real part corrupts data on these, so count them as faults
	wire badCmd = (memActivate && rowOpen_q) || ((memRead || memDummyRead) && !rowOpen_q);
	// track the open row and count every command
	always @(posedge ref_clk) begin
		if (rst) begin
			rowOpen_q <= 1'h0;
			rdCnt_q <= 16'h0;
			dumCnt_q <= 16'h0;
			actCnt_q <= 16'h0;
			preCnt_q <= 16'h0;
			errCnt_q <= 16'h0;
			lastAddr_q <= 32'h0;
		end else begin
			if (memActivate)
				rowOpen_q <= 1'h1;
			else if (memPrecharge)
				rowOpen_q <= 1'h0;
			rdCnt_q <= rdCnt_q + {15'h0, memRead};
			dumCnt_q <= dumCnt_q + {15'h0, memDummyRead};
			actCnt_q <= actCnt_q + {15'h0, memActivate};
			preCnt_q <= preCnt_q + {15'h0, memPrecharge};
			errCnt_q <= errCnt_q + {15'h0, badCmd};
			if (memRead)
				lastAddr_q <= memAddr;
		end
	end
endmodule

// ### verification/sdram_code_fetch_timing_bench.sv
// self-checking bench for the sdram code fetch timing block
// assumes default timing parameters and the behavioural sdram model
`timescale 1ns/10ps
module sdram_code_fetch_timing_bench;
	reg ref_clk = 1'h0;
	reg rst = 1'h1;
	reg [1:0] instrPackingSelect = 2'h1;
	reg cacheEnable = 1'h1;
	reg reqValid = 1'h0;
	reg [23:0] reqAddr = 24'h200000;
	reg delayedBranch = 1'h0;
	reg [1:0] loopMode = 2'h0;
	reg loopFirst = 1'h0;
	wire reqReady, execStrobe, stallActive, flushPulse, seqFetch, cacheHit;
	wire memActivate, memPrecharge, memRead, memDummyRead;
	wire [2:0] pipeStage;
	wire [31:0] memAddr, lastAddr;
	wire [15:0] rdCnt, dumCnt, actCnt, preCnt, errCnt;
	integer miscompares = 0;
	integer checks_done = 0;
	integer i;
	// 250 mhz clock
	always #2 ref_clk = ~ref_clk;
	sdcf_fetch_timing sdcf_fetch_timing_i (.ref_clk(ref_clk), .rst(rst),
		.instrPackingSelect(instrPackingSelect), .cacheEnable(cacheEnable),
		.reqValid(reqValid), .reqAddr(reqAddr), .delayedBranch(delayedBranch),
		.loopMode(loopMode), .loopFirst(loopFirst), .reqReady(reqReady),
		.execStrobe(execStrobe), .stallActive(stallActive), .flushPulse(flushPulse),
		.pipeStage(pipeStage), .seqFetch(seqFetch), .cacheHit(cacheHit),
		.memActivate(memActivate), .memPrecharge(memPrecharge), .memRead(memRead),
		.memDummyRead(memDummyRead), .memAddr(memAddr));
	sdcf_sdram_model sdcf_sdram_model_i (.ref_clk(ref_clk), .rst(rst),
		.memActivate(memActivate), .memPrecharge(memPrecharge), .memRead(memRead),
		.memDummyRead(memDummyRead), .memAddr(memAddr), .rdCnt_q(rdCnt),
		.dumCnt_q(dumCnt), .actCnt_q(actCnt), .preCnt_q(preCnt), .errCnt_q(errCnt),
		.lastAddr_q(lastAddr));
	task check(input [31:0] seen, input [31:0] exp, input string what);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0s expected %0h seen %0h", what, exp, seen);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", checks_done, miscompares);
			if (miscompares == 0 && checks_done > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// reset for 16 edges, released just after an edge
	task do_reset;
		begin
			rst = 1'h1;
			repeat (16) @(posedge ref_clk);
			#1 rst = 1'h0;
			check(reqReady, 1, "ready after reset");
			check(pipeStage, 0, "stages after reset");
		end
	endtask
	// offer one fetch, count edges from accept to execution
	task fetch(input [23:0] a, input db, input [1:0] lm, input lf, input integer d,
		input string what);
		integer n;
		begin
			reqAddr = a;
			delayedBranch = db;
			loopMode = lm;
			loopFirst = lf;
			reqValid = 1'h1;
			n = 0;
			while (reqReady !== 1'h1 && n < 100) begin
				@(posedge ref_clk);
				#1 n = n + 1;
			end
			@(posedge ref_clk);
			#1 reqValid = 1'h0;
			n = 0;
			do begin
				@(posedge ref_clk);
				#1 n = n + 1;
			end while (execStrobe !== 1'h1 && n < 100);
			check(n, d, what);
			if (n >= 100)
				stop_test;
		end
	endtask
	// cold fill in every packing mode
	task t_cold_modes;
		integer p, r;
		begin
			for (p = 0; p < 4; p = p + 1) begin
				r = (p == 3) ? 6 : p + 1;
				instrPackingSelect = p[1:0];
				do_reset;
				fetch(24'h200000, 1'h0, 2'h0, 1'h0, 3 + 3 * r, "cold fill");
				check(rdCnt, r, "cold reads");
				check(actCnt, 1, "cold activate");
				check(pipeStage, 7, "stages filled");
			end
			instrPackingSelect = 2'h1;
		end
	endtask
	// straight code, near and far branches, page crossing
	task t_branches;
		begin
			do_reset;
			fetch(24'h200000, 1'h0, 2'h0, 1'h0, 9, "first fetch");
			check(lastAddr, 32'h200001, "word pair");
			fetch(24'h200001, 1'h0, 2'h0, 1'h0, 2, "sequential");
			check(seqFetch, 1, "seq class");
			fetch(24'h200010, 1'h0, 2'h0, 1'h0, 10, "branch");
			check(seqFetch, 0, "branch class");
			fetch(24'h200020, 1'h1, 2'h0, 1'h0, 6, "db branch");
			fetch(24'h200100, 1'h0, 2'h0, 1'h0, 13, "far branch");
			fetch(24'h200200, 1'h1, 2'h0, 1'h0, 9, "far db branch");
			check(preCnt, 2, "precharges");
			fetch(24'h20027f, 1'h0, 2'h0, 1'h0, 10, "page end");
			fetch(24'h200280, 1'h0, 2'h0, 1'h0, 8, "page cross");
			check(lastAddr, 32'h200501, "cross reads");
			check(errCnt, 0, "branch command order");
		end
	endtask
	// single instruction loops, data and program memory
	task t_loops;
		begin
			do_reset;
			cacheEnable = 1'h1;
			fetch(24'h200000, 1'h0, 2'h0, 1'h0, 9, "loop entry");
			for (i = 0; i < 3; i = i + 1)
				fetch(24'h200002, 1'h0, 2'h1, 1'h0, 6, "dm loop");
			@(posedge ref_clk);
			#1 check(dumCnt, 12, "dummy reads");
			check(rdCnt, 8, "dm loop reads");
			for (i = 0; i < 5; i = i + 1) begin
				fetch(24'h200003, 1'h0, 2'h2, i == 0, i < 3 ? 8 : 1, "pm loop");
				check(cacheHit, i > 2, "cache use");
			end
			cacheEnable = 1'h0;
			for (i = 0; i < 5; i = i + 1) begin
				fetch(24'h200003, 1'h0, 2'h2, i == 0, 8, "pm uncached");
				check(cacheHit, 0, "no cache");
			end
		end
	endtask
	initial begin
		t_cold_modes;
		t_branches;
		t_loops;
		check(errCnt, 0, "command order");
		stop_test;
	end
endmodule
